// ---- dv/pes_host.sv ----
// pes_host: behavioural host driving the slave port strobes and data bus
`timescale 1ns/1ns
module pes_host
(
    // clock
    input wire logic pclk,
    // strobes, active low: bit0 read, bit1 write, bit2 select
    output logic [2:0] strobe_n,
    // host data bus
    output logic [7:0] bus_out,
    input wire logic [7:0] bus_in,
    input wire logic bus_oe
);
    // =========================================================
    // idle: strobes pulled high
    initial
    begin
        strobe_n = 3'h7;
        bus_out = 8'h00;
    end

    // =========================================================
    // write cycle: select and write low, data held after release
    task write_word(input logic [7:0] d);
        @(posedge pclk);
        bus_out <= d;
        strobe_n <= 3'h1;
        repeat (6) @(posedge pclk);
        strobe_n <= 3'h7;
        repeat (6) @(posedge pclk);
        bus_out <= ~d;
        repeat (6) @(posedge pclk);
    endtask : write_word

    // read cycle: select and read low, sample the bus before release
    task read_word(output logic [7:0] d, output logic oe);
        @(posedge pclk);
        strobe_n <= 3'h2;
        repeat (6) @(posedge pclk);
        d = bus_in;
        oe = bus_oe;
        strobe_n <= 3'h7;
        repeat (8) @(posedge pclk);
    endtask : read_word
endmodule : pes_host

// ---- dv/pes_port_tb.sv ----
// pes_port_tb: self-checking bench of the port-e block
`timescale 1ns/1ns
module pes_port_tb;
    import pes_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic port_pin3 = 1'b1;
    logic mc_cfg = 1'b0;
    logic [2:0] gp = 3'h7;
    logic [31:0] prdata;
    logic pready, pslverr, master_clear_in, host_data_oe, irq, an5, an6, an7, hoe, lerr;
    logic [2:0] pin_in, pin_out, pin_oe, strobe_n;
    logic [7:0] host_data_in, host_data_out, bus_out, hd;
    logic [31:0] seed = 32'h8;
    logic [31:0] rd, r;
    logic sl;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    always #25 pclk = ~pclk;

    // =========================================================
    // wire levels: design drives enabled pins, else host and bench
    assign pin_in = (pin_out & pin_oe) | (gp & strobe_n & ~pin_oe);
    assign host_data_in = host_data_oe ? host_data_out : bus_out;

    pes_port pes_port_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .port_pin3(port_pin3), .master_clear_cfg(mc_cfg), .master_clear_in(master_clear_in),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .analog_channel5(an5), .analog_channel6(an6), .analog_channel7(an7), .irq(irq));

    pes_host pes_host_inst (.pclk(pclk), .strobe_n(strobe_n), .bus_out(bus_out),
        .bus_in(host_data_in), .bus_oe(host_data_oe));

    // =========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] lv_exp(input logic [2:0] p, input logic [7:0] an, input logic p3,
        input logic c);
        return {28'h0, p3 & ~c, p & ~an[7:5]};
    endfunction : lv_exp

    task check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        check(rd, want);
    endtask : rd_chk

    task finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    // =========================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check({29'h0, an7, an6, an5}, 32'h7);
        check({29'h0, pin_oe}, 32'h0);
        check({31'h0, irq}, 32'h0);
        rd_chk(PES_OFF_DIR_CTRL, 32'h07);
        rd_chk(PES_OFF_ANALOG_SEL, 32'hFF);
        repeat (4) @(posedge pclk);
        rd_chk(PES_OFF_PIN_LEVELS, lv_exp(3'h7, 8'hFF, 1'b1, 1'b0));
        $display("reset test done");
        for (int i = 0; i < 24; i++)
        begin
            r = rnd();
            sl = r[11] & ~(&r[10:8]);
            gp <= r[2:0];
            port_pin3 <= r[3];
            mc_cfg <= r[4];
            wr(PES_OFF_DIR_CTRL, {24'h0, 3'h0, sl, 1'b0, r[10:8]});
            wr(PES_OFF_OUTPUT_LATCH, {r[31:16], 13'h0, r[14:12]});
            wr(PES_OFF_ANALOG_SEL, {24'h0, r[23:16]});
            repeat (6) @(posedge pclk);
            check({29'h0, pin_out}, {29'h0, r[14:12]});
            check({29'h0, pin_oe}, {29'h0, ~r[10:8]});
            check({29'h0, an7, an6, an5}, {29'h0, r[23:21]});
            check({31'h0, master_clear_in}, {31'h0, r[4] & ~r[3]});
            rd_chk(PES_OFF_PIN_LEVELS, lv_exp((r[2:0] & r[10:8]) | (r[14:12] & ~r[10:8]), r[23:16], r[3],
                r[4]));
            rd_chk(PES_OFF_OUTPUT_LATCH, {29'h0, r[14:12]});
            rd_chk(PES_OFF_DIR_CTRL, {27'h0, sl, 1'b0, r[10:8]});
        end
        $display("gpio test done");
        @(posedge pclk);
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        check({31'h0, pready}, 32'h0);
        check({29'h0, pin_out}, {29'h0, r[14:12]});
        ce <= 1'b1;
        gp <= 3'h7;
        wr(PES_OFF_ANALOG_SEL, 32'h0);
        wr(PES_OFF_DIR_CTRL, 32'h17);
        wr(PES_OFF_IRQ_ENABLE, 32'h7);
        pes_host_inst.write_word(8'hA5);
        rd_chk(PES_OFF_DIR_CTRL, 32'h97);
        check({31'h0, irq}, 32'h1);
        pes_host_inst.write_word(8'h5A);
        rd_chk(PES_OFF_DIR_CTRL, 32'hB7);
        wr(PES_OFF_DIR_CTRL, 32'h37);
        rd_chk(PES_OFF_DIR_CTRL, 32'hB7);
        wr(PES_OFF_DIR_CTRL, 32'h17);
        rd_chk(PES_OFF_SLAVE_IN, 32'h5A);
        rd_chk(PES_OFF_DIR_CTRL, 32'h17);
        wr(PES_OFF_SLAVE_OUT, 32'hC3);
        rd_chk(PES_OFF_DIR_CTRL, 32'h57);
        pes_host_inst.read_word(hd, hoe);
        check({31'h0, hoe}, 32'h1);
        check({24'h0, hd}, 32'hC3);
        rd_chk(PES_OFF_DIR_CTRL, 32'h17);
        rd_chk(PES_OFF_IRQ_STATUS, 32'h7);
        wr(PES_OFF_IRQ_CLEAR, 32'h7);
        rd_chk(PES_OFF_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(PES_OFF_IRQ_ENABLE, 32'h0);
        pes_host_inst.write_word(8'h3C);
        rd_chk(PES_OFF_IRQ_STATUS, 32'h1);
        check({31'h0, irq}, 32'h0);
        rd_chk(PES_OFF_SLAVE_IN, 32'h3C);
        wr(PES_OFF_DIR_CTRL, 32'h07);
        pes_host_inst.write_word(8'h11);
        rd_chk(PES_OFF_DIR_CTRL, 32'h07);
        apb(1'b0, 8'hFC, 32'h0);
        check({31'h0, lerr}, 32'h1);
        check(rd, 32'h0);
        $display("slave test done");
        finish_test();
    end
endmodule : pes_port_tb

// ---- hdl/pes_apb.sv ----
// pes_apb: apb phase decode and register select
`timescale 1ns/1ns
module pes_apb
    import pes_pkg::*;
(
    // apb control
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    output logic pready,
    output logic pslverr,
    // decoded strobes
    output logic setup_rd,
    output logic acc_wr,
    output logic acc_rd,
    output logic [PES_NUM_REGS-1:0] reg_sel
);

    // =========================================================
    // address to one-hot select, zero for unmapped
    function automatic logic [PES_NUM_REGS-1:0] pes_decode(input logic [7:0] a);
        logic [PES_NUM_REGS-1:0] d;
        d = '0;
        unique case (a)
            PES_OFF_PIN_LEVELS: d[PES_SEL_PIN_LEVELS] = 1'b1;
            PES_OFF_OUTPUT_LATCH: d[PES_SEL_OUTPUT_LATCH] = 1'b1;
            PES_OFF_DIR_CTRL: d[PES_SEL_DIR_CTRL] = 1'b1;
            PES_OFF_ANALOG_SEL: d[PES_SEL_ANALOG_SEL] = 1'b1;
            PES_OFF_SLAVE_IN: d[PES_SEL_SLAVE_IN] = 1'b1;
            PES_OFF_SLAVE_OUT: d[PES_SEL_SLAVE_OUT] = 1'b1;
            PES_OFF_IRQ_STATUS: d[PES_SEL_IRQ_STATUS] = 1'b1;
            PES_OFF_IRQ_ENABLE: d[PES_SEL_IRQ_ENABLE] = 1'b1;
            PES_OFF_IRQ_CLEAR: d[PES_SEL_IRQ_CLEAR] = 1'b1;
            default: d = '0;
        endcase
        return d;
    endfunction : pes_decode

    assign reg_sel = pes_decode(paddr);
    assign pready = ce;
    assign pslverr = psel & penable & ~(|reg_sel);
    assign setup_rd = ce & psel & ~penable & ~pwrite;
    assign acc_wr = ce & psel & penable & pwrite;
    assign acc_rd = ce & psel & penable & ~pwrite;

endmodule : pes_apb

// ---- hdl/pes_pkg.sv ----
// pes_pkg: register map, field layout, reset values and state type of the port-e block
package pes_pkg;

    // =========================================================
    // register byte offsets
    localparam logic [7:0] PES_OFF_PIN_LEVELS = 8'h00;
    localparam logic [7:0] PES_OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] PES_OFF_DIR_CTRL = 8'h08;
    localparam logic [7:0] PES_OFF_ANALOG_SEL = 8'h0C;
    localparam logic [7:0] PES_OFF_SLAVE_IN = 8'h10;
    localparam logic [7:0] PES_OFF_SLAVE_OUT = 8'h14;
    localparam logic [7:0] PES_OFF_IRQ_STATUS = 8'h18;
    localparam logic [7:0] PES_OFF_IRQ_ENABLE = 8'h1C;
    localparam logic [7:0] PES_OFF_IRQ_CLEAR = 8'h20;
    localparam int PES_NUM_REGS = 9;

    // =========================================================
    // register select indices (one-hot position)
    localparam int PES_SEL_PIN_LEVELS = 0;
    localparam int PES_SEL_OUTPUT_LATCH = 1;
    localparam int PES_SEL_DIR_CTRL = 2;
    localparam int PES_SEL_ANALOG_SEL = 3;
    localparam int PES_SEL_SLAVE_IN = 4;
    localparam int PES_SEL_SLAVE_OUT = 5;
    localparam int PES_SEL_IRQ_STATUS = 6;
    localparam int PES_SEL_IRQ_ENABLE = 7;
    localparam int PES_SEL_IRQ_CLEAR = 8;

    // =========================================================
    // field positions
    localparam int PES_BIT_IN_FULL = 7;
    localparam int PES_BIT_OUT_FULL = 6;
    localparam int PES_BIT_IN_OVF = 5;
    localparam int PES_BIT_SLAVE_SEL = 4;
    localparam int PES_BIT_ANS_PIN0 = 5;
    localparam int PES_IRQ_IN_FULL = 0;
    localparam int PES_IRQ_OUT_READ = 1;
    localparam int PES_IRQ_OVF = 2;

    // =========================================================
    // reset values
    localparam logic [2:0] PES_RST_DIR = 3'h7;
    localparam logic [2:0] PES_RST_LATCH = 3'h0;
    localparam logic [7:0] PES_RST_ANALOG_SEL = 8'hFF;
    localparam logic [12:0] PES_SYNC_RST = 13'h0007;

    // =========================================================
    // complete register state of the top module
    typedef struct packed {
        logic [2:0] latch;
        logic [2:0] dir;
        logic slave_sel;
        logic in_full;
        logic out_full;
        logic in_ovf;
        logic [7:0] analog_select_reg;
        logic [7:0] in_data;
        logic [7:0] out_data;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic wr_act;
        logic rd_act;
        logic [31:0] prdata;
    } pes_state_t;

endpackage : pes_pkg

// ---- hdl/pes_port.sv ----
// pes_port: port-e pins, direction/slave control, analog select, slave buffers and interrupt
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ns
module pes_port
    import pes_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins 0..2, two-way
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    // pin 3 and master clear
    input wire logic port_pin3,
    input wire logic master_clear_cfg,
    output logic master_clear_in,
    // host data bus of the slave port
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    // analog routing to converter
    output logic analog_channel5,
    output logic analog_channel6,
    output logic analog_channel7,
    // interrupt
    output logic irq
);

    pes_state_t s;
    pes_state_t next_s;

    logic [12:0] sync_q;
    logic [2:0] pin_f;
    logic pin3_f;
    logic cfg_f;
    logic [7:0] data_f;
    logic setup_rd;
    logic acc_wr;
    logic acc_rd;
    logic [PES_NUM_REGS-1:0] reg_sel;
    logic slave_mode;
    logic wr_act_now;
    logic rd_act_now;
    logic host_wr_end;
    logic host_rd_end;
    logic cpu_in_read;
    logic cpu_out_write;
    logic [2:0] dig_in;
    logic [3:0] port_read;
    logic [2:0] irq_set;
    logic [31:0] rdata;

    // =========================================================
    // input synchroniser and bus decode
    pes_sync #(
        .W(13),
        .RST(PES_SYNC_RST)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .raw({master_clear_cfg, host_data_in, port_pin3, pin_in}),
        .q(sync_q)
    );

    assign pin_f = sync_q[2:0];
    assign pin3_f = sync_q[3];
    assign data_f = sync_q[11:4];
    assign cfg_f = sync_q[12];

    pes_apb u_apb (
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .setup_rd(setup_rd),
        .acc_wr(acc_wr),
        .acc_rd(acc_rd),
        .reg_sel(reg_sel)
    );

    // =========================================================
    // pin reads and host strobes
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            dig_in[i] = pin_f[i] & ~s.analog_select_reg[PES_BIT_ANS_PIN0 + i];
        end
    end

    assign port_read = {pin3_f & ~cfg_f, dig_in};
    assign slave_mode = s.slave_sel & (&s.dir);
    assign wr_act_now = slave_mode & ~pin_f[2] & ~pin_f[1];
    assign rd_act_now = slave_mode & ~pin_f[2] & ~pin_f[0];
    assign host_wr_end = s.wr_act & ~wr_act_now;
    assign host_rd_end = s.rd_act & ~rd_act_now;
    assign cpu_in_read = acc_rd & reg_sel[PES_SEL_SLAVE_IN];
    assign cpu_out_write = acc_wr & reg_sel[PES_SEL_SLAVE_OUT];

    assign irq_set[PES_IRQ_IN_FULL] = host_wr_end;
    assign irq_set[PES_IRQ_OUT_READ] = host_rd_end & s.out_full;
    assign irq_set[PES_IRQ_OVF] = host_wr_end & s.in_full;

    // =========================================================
    // read mux
    always_comb
    begin
        rdata = 32'h0000_0000;
        if (reg_sel[PES_SEL_PIN_LEVELS])
        begin
            rdata[3:0] = port_read;
        end
        if (reg_sel[PES_SEL_OUTPUT_LATCH])
        begin
            rdata[2:0] = s.latch;
        end
        if (reg_sel[PES_SEL_DIR_CTRL])
        begin
            rdata[PES_BIT_IN_FULL] = s.in_full;
            rdata[PES_BIT_OUT_FULL] = s.out_full;
            rdata[PES_BIT_IN_OVF] = s.in_ovf;
            rdata[PES_BIT_SLAVE_SEL] = s.slave_sel;
            rdata[2:0] = s.dir;
        end
        if (reg_sel[PES_SEL_ANALOG_SEL])
        begin
            rdata[7:0] = s.analog_select_reg;
        end
        if (reg_sel[PES_SEL_SLAVE_IN])
        begin
            rdata[7:0] = s.in_data;
        end
        if (reg_sel[PES_SEL_IRQ_STATUS])
        begin
            rdata[2:0] = s.irq_stat;
        end
        if (reg_sel[PES_SEL_IRQ_ENABLE])
        begin
            rdata[2:0] = s.irq_en;
        end
    end

    // =========================================================
    // next state
    always_comb
    begin
        next_s = s;
        next_s.wr_act = wr_act_now;
        next_s.rd_act = rd_act_now;
        if (setup_rd)
        begin
            next_s.prdata = rdata;
        end
        if (acc_wr)
        begin
            if (reg_sel[PES_SEL_PIN_LEVELS] || reg_sel[PES_SEL_OUTPUT_LATCH])
            begin
                next_s.latch = pwdata[2:0];
            end
            if (reg_sel[PES_SEL_DIR_CTRL])
            begin
                next_s.dir = pwdata[2:0];
                next_s.slave_sel = pwdata[PES_BIT_SLAVE_SEL];
                if (!pwdata[PES_BIT_IN_OVF])
                begin
                    next_s.in_ovf = 1'b0;
                end
            end
            if (reg_sel[PES_SEL_ANALOG_SEL])
            begin
                next_s.analog_select_reg = pwdata[7:0];
            end
            if (reg_sel[PES_SEL_IRQ_ENABLE])
            begin
                next_s.irq_en = pwdata[2:0];
            end
            if (reg_sel[PES_SEL_IRQ_CLEAR])
            begin
                next_s.irq_stat = s.irq_stat & ~pwdata[2:0];
            end
        end
        // cpu side of the slave buffers
        if (cpu_in_read)
        begin
            next_s.in_full = 1'b0;
        end
        if (cpu_out_write)
        begin
            next_s.out_data = pwdata[7:0];
            next_s.out_full = 1'b1;
        end
        else if (host_rd_end)
        begin
            next_s.out_full = 1'b0;
        end
        // host write wins over a cpu read or clear in the same cycle
        if (host_wr_end)
        begin
            next_s.in_data = data_f;
            next_s.in_full = 1'b1;
            if (s.in_full)
            begin
                next_s.in_ovf = 1'b1;
            end
        end
        next_s.irq_stat = next_s.irq_stat | irq_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.dir <= PES_RST_DIR;
            s.latch <= PES_RST_LATCH;
            s.analog_select_reg <= PES_RST_ANALOG_SEL;
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    // =========================================================
    // outputs
    assign prdata = s.prdata;
    assign pin_out = s.latch;
    assign pin_oe = ~s.dir;
    assign master_clear_in = cfg_f & ~pin3_f;
    assign host_data_out = s.out_data;
    assign host_data_oe = rd_act_now;
    assign analog_channel5 = s.analog_select_reg[PES_BIT_ANS_PIN0];
    assign analog_channel6 = s.analog_select_reg[PES_BIT_ANS_PIN0 + 1];
    assign analog_channel7 = s.analog_select_reg[PES_BIT_ANS_PIN0 + 2];
    assign irq = |(s.irq_stat & s.irq_en);

    // =========================================================
    // assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_in_full_set: assert property (ce && host_wr_end |=> s.in_full)
        else $error("input full flag not set by host write");

    a_in_full_clear: assert property (ce && cpu_in_read && !host_wr_end |=> !s.in_full)
        else $error("input full flag not cleared by cpu read");

    a_out_full_clear: assert property (ce && host_rd_end && !cpu_out_write |=> !s.out_full)
        else $error("output full flag not cleared by host read");

    a_out_full_set: assert property (ce && cpu_out_write |=> s.out_full && host_data_out == $past(pwdata[7:0]))
        else $error("output full flag or data wrong after cpu write");

    a_ovf_set: assert property (ce && host_wr_end && s.in_full |=> s.in_ovf)
        else $error("overflow not flagged");

    a_ovf_sticky: assert property (s.in_ovf && !(acc_wr && reg_sel[PES_SEL_DIR_CTRL]) |=> s.in_ovf)
        else $error("overflow cleared without software write");

    a_bit3_zero: assert property (ce && setup_rd && reg_sel[PES_SEL_DIR_CTRL] |=> prdata[3] == 1'b0)
        else $error("unimplemented control bit read nonzero");

    a_analog_read_zero: assert property (
        ce && setup_rd && reg_sel[PES_SEL_PIN_LEVELS] && s.analog_select_reg[PES_BIT_ANS_PIN0] |=> prdata[0] == 1'b0)
        else $error("analog pin read nonzero");

    a_upper_zero: assert property (
        ce && setup_rd && (reg_sel[PES_SEL_PIN_LEVELS] || reg_sel[PES_SEL_OUTPUT_LATCH]) |=> prdata[31:4] == 28'h0)
        else $error("upper port bits read nonzero");

    a_out_drive: assert property (
        ce && acc_wr && reg_sel[PES_SEL_OUTPUT_LATCH] |=> pin_out == $past(pwdata[2:0]))
        else $error("output pin not driven from latch");

    a_strobe_gate: assert property (!s.slave_sel |-> !wr_act_now && !rd_act_now && !host_data_oe)
        else $error("strobes active outside slave mode");

    a_dir_write: assert property (
        ce && acc_wr && reg_sel[PES_SEL_DIR_CTRL] |=> pin_oe == ~$past(pwdata[2:0]))
        else $error("direction write not applied to pin drivers");

    a_dir_read: assert property (
        ce && setup_rd && reg_sel[PES_SEL_DIR_CTRL] |=> prdata[2:0] == $past(s.dir))
        else $error("direction bits read back wrong");

    a_pin_read: assert property (
        ce && setup_rd && reg_sel[PES_SEL_PIN_LEVELS] && !s.analog_select_reg[PES_BIT_ANS_PIN0]
        |=> prdata[0] == $past(pin_f[0]))
        else $error("digital pin level not returned");

    a_pin3_cfg: assert property (
        ce && setup_rd && reg_sel[PES_SEL_PIN_LEVELS] && cfg_f |=> prdata[3] == 1'b0)
        else $error("pin 3 read nonzero while master clear");

    a_latch_pin3: assert property (
        ce && setup_rd && reg_sel[PES_SEL_OUTPUT_LATCH] |=> prdata[3] == 1'b0)
        else $error("latch bit for input-only pin read nonzero");

    a_analog_route: assert property (
        ce && acc_wr && reg_sel[PES_SEL_ANALOG_SEL]
        |=> {analog_channel7, analog_channel6, analog_channel5} == $past(pwdata[7:5]))
        else $error("analog routing does not follow select bits");

    a_analog_drive: assert property (
        ce && acc_wr && reg_sel[PES_SEL_OUTPUT_LATCH] && !s.dir[2] && s.analog_select_reg[PES_BIT_ANS_PIN0 + 2]
        |=> pin_oe[2] && pin_out[2] == $past(pwdata[2]))
        else $error("analog select stopped output drive");

    a_master_clear_in_off: assert property (!cfg_f |-> !master_clear_in)
        else $error("master clear raised while not configured");

    a_slave_dir: assert property (s.slave_sel && !(&s.dir) |-> !host_data_oe)
        else $error("host read strobe honoured with output pins");

    a_ovf_clear: assert property (
        ce && acc_wr && reg_sel[PES_SEL_DIR_CTRL] && !pwdata[PES_BIT_IN_OVF] && !host_wr_end |=> !s.in_ovf)
        else $error("overflow not cleared by writing zero");

    a_ovf_write_one: assert property (
        ce && acc_wr && reg_sel[PES_SEL_DIR_CTRL] && !s.in_ovf && !host_wr_end |=> !s.in_ovf)
        else $error("overflow set by software write");

    a_in_word: assert property (ce && host_wr_end |=> s.in_data == $past(data_f))
        else $error("host word not captured at end of write");

    a_irq_mask: assert property (ce && acc_wr && reg_sel[PES_SEL_IRQ_ENABLE] && pwdata[2:0] == 3'h0 |=> !irq)
        else $error("interrupt raised with all sources masked");

endmodule : pes_port

// ---- hdl/pes_sync.sv ----
// pes_sync: three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
module pes_sync
    import pes_pkg::*;
#(
    parameter int W = 13,
    parameter logic [W-1:0] RST = '0
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // raw and filtered levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } pes_sync_t;

    pes_sync_t s;
    pes_sync_t next_s;

    // =========================================================
    // filter: a bit changes once stages two and three agree
    always_comb
    begin
        next_s = s;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++)
        begin
            if (s.s2[i] == s.s3[i])
            begin
                next_s.q[i] = s.s2[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= {RST, RST, RST, RST};
        end
        else if (ce)
        begin
            s <= next_s;
        end
    end

    assign q = s.q;

endmodule : pes_sync
